// ===== hw/irq_steer_pkg.sv
// Constants for the PCI interrupt to ISA IRQ steering block
package irq_steer_pkg;

   localparam int ADDR_W = 12;
   localparam int NUM_PCI = 8;
   localparam int NUM_SRC = 10;
   localparam int NIBBLE = 4;

   // Byte address of a register index on the 32-bit bus
   function automatic logic [11:0] byte_addr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   localparam logic [7:0] IDX_ROUTE_12 = 8'h48;
   localparam logic [7:0] IDX_ROUTE_34 = 8'h49;
   localparam logic [7:0] IDX_ROUTE_56 = 8'h4a;
   localparam logic [7:0] IDX_ROUTE_78 = 8'h4b;
   localparam logic [7:0] IDX_L2E = 8'h4c;
   localparam logic [7:0] IDX_STEER = 8'h4d;
   localparam logic [7:0] IDX_INT_STATUS = 8'h60;
   localparam logic [7:0] IDX_INT_MASK = 8'h61;
   localparam logic [7:0] IDX_RAW_LEVEL = 8'h62;

   localparam logic [11:0] ADDR_ROUTE_12 = byte_addr(IDX_ROUTE_12);
   localparam logic [11:0] ADDR_ROUTE_34 = byte_addr(IDX_ROUTE_34);
   localparam logic [11:0] ADDR_ROUTE_56 = byte_addr(IDX_ROUTE_56);
   localparam logic [11:0] ADDR_ROUTE_78 = byte_addr(IDX_ROUTE_78);
   localparam logic [11:0] ADDR_L2E = byte_addr(IDX_L2E);
   localparam logic [11:0] ADDR_STEER = byte_addr(IDX_STEER);
   localparam logic [11:0] ADDR_INT_STATUS = byte_addr(IDX_INT_STATUS);
   localparam logic [11:0] ADDR_INT_MASK = byte_addr(IDX_INT_MASK);
   localparam logic [11:0] ADDR_RAW_LEVEL = byte_addr(IDX_RAW_LEVEL);

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [9:0] EVT_RESET = 10'h000;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // Routing field codes
   localparam logic [3:0] CODE_OFF = 4'h0;
   localparam logic [3:0] CODE_IRQ9 = 4'h1;
   localparam logic [3:0] CODE_IRQ3 = 4'h2;
   localparam logic [3:0] CODE_IRQ10 = 4'h3;
   localparam logic [3:0] CODE_IRQ4 = 4'h4;
   localparam logic [3:0] CODE_IRQ5 = 4'h5;
   localparam logic [3:0] CODE_IRQ7 = 4'h6;
   localparam logic [3:0] CODE_IRQ6 = 4'h7;
   localparam logic [3:0] CODE_IRQ1 = 4'h8;
   localparam logic [3:0] CODE_IRQ11 = 4'h9;
   localparam logic [3:0] CODE_RSV_A = 4'ha;
   localparam logic [3:0] CODE_IRQ12 = 4'hb;
   localparam logic [3:0] CODE_RSV_C = 4'hc;
   localparam logic [3:0] CODE_IRQ14 = 4'hd;
   localparam logic [3:0] CODE_RSV_E = 4'he;
   localparam logic [3:0] CODE_IRQ15 = 4'hf;

   // One-hot ISA IRQ lines, bit n is IRQn
   localparam logic [15:0] IRQ_NONE = 16'h0000;
   localparam logic [15:0] IRQ1_BIT = 16'h0002;
   localparam logic [15:0] IRQ3_BIT = 16'h0008;
   localparam logic [15:0] IRQ4_BIT = 16'h0010;
   localparam logic [15:0] IRQ5_BIT = 16'h0020;
   localparam logic [15:0] IRQ6_BIT = 16'h0040;
   localparam logic [15:0] IRQ7_BIT = 16'h0080;
   localparam logic [15:0] IRQ9_BIT = 16'h0200;
   localparam logic [15:0] IRQ10_BIT = 16'h0400;
   localparam logic [15:0] IRQ11_BIT = 16'h0800;
   localparam logic [15:0] IRQ12_BIT = 16'h1000;
   localparam logic [15:0] IRQ14_BIT = 16'h4000;
   localparam logic [15:0] IRQ15_BIT = 16'h8000;

   localparam int EDGE_PULSE_LEN = 2;

endpackage

// ===== hw/irq_route_decode.sv
// Decoder from a 4-bit routing field to one-hot ISA IRQ lines
`timescale 1ns/1ps
`default_nettype none
module irq_route_decode (
   input  wire logic [3:0]  code,
   output logic      [15:0] irq_onehot
);
   always_comb begin
      unique case (code)
         irq_steer_pkg::CODE_IRQ9:  irq_onehot = irq_steer_pkg::IRQ9_BIT;
         irq_steer_pkg::CODE_IRQ3:  irq_onehot = irq_steer_pkg::IRQ3_BIT;
         irq_steer_pkg::CODE_IRQ10: irq_onehot = irq_steer_pkg::IRQ10_BIT;
         irq_steer_pkg::CODE_IRQ4:  irq_onehot = irq_steer_pkg::IRQ4_BIT;
         irq_steer_pkg::CODE_IRQ5:  irq_onehot = irq_steer_pkg::IRQ5_BIT;
         irq_steer_pkg::CODE_IRQ7:  irq_onehot = irq_steer_pkg::IRQ7_BIT;
         irq_steer_pkg::CODE_IRQ6:  irq_onehot = irq_steer_pkg::IRQ6_BIT;
         irq_steer_pkg::CODE_IRQ1:  irq_onehot = irq_steer_pkg::IRQ1_BIT;
         irq_steer_pkg::CODE_IRQ11: irq_onehot = irq_steer_pkg::IRQ11_BIT;
         irq_steer_pkg::CODE_IRQ12: irq_onehot = irq_steer_pkg::IRQ12_BIT;
         irq_steer_pkg::CODE_IRQ14: irq_onehot = irq_steer_pkg::IRQ14_BIT;
         irq_steer_pkg::CODE_IRQ15: irq_onehot = irq_steer_pkg::IRQ15_BIT;
         // Off and the three reserved codes drive nothing
         irq_steer_pkg::CODE_OFF,
         irq_steer_pkg::CODE_RSV_A,
         irq_steer_pkg::CODE_RSV_C,
         irq_steer_pkg::CODE_RSV_E: irq_onehot = irq_steer_pkg::IRQ_NONE;
      endcase
   end
endmodule
`default_nettype wire

// ===== hw/pci_int_to_isa_irq_steering.sv
// PCI interrupt to ISA IRQ steering with APB registers and event interrupt
`timescale 1ns/1ps
`default_nettype none
module pci_int_to_isa_irq_steering #(
   parameter int PULSE_LEN = irq_steer_pkg::EDGE_PULSE_LEN
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  pci_int_lines,
   input  wire logic        steer_irq_first_input,
   input  wire logic        steer_irq_second_input,
   output logic      [15:0] isa_irq,
   output logic             irq
);
   localparam int NS = irq_steer_pkg::NUM_SRC;
   localparam int NP = irq_steer_pkg::NUM_PCI;
   localparam int NB = irq_steer_pkg::NIBBLE;
   localparam int CW = $clog2(PULSE_LEN + 1);

   logic [7:0]    pci_int_route_1_2;
   logic [7:0]    pci_int_route_3_4;
   logic [7:0]    pci_int_route_5_6;
   logic [7:0]    pci_int_route_7_8;
   logic [7:0]    level_to_edge_enable;
   logic [7:0]    steerable_irq_route;
   logic [NS-1:0] int_status;
   logic [NS-1:0] int_mask;

   logic [NS-1:0] raw_level;
   logic [NS-1:0] prev_level;
   logic [NS-1:0] rise;
   logic [NS-1:0] src;
   logic [NP-1:0] pulse_on;
   logic [CW-1:0] pulse_cnt [NP];
   logic [3:0]    route_code [NS];
   logic [15:0]   route_hot [NS];
   logic [15:0]   next_isa_irq;
   logic [31:0]   next_prdata;
   logic          next_hit;
   logic          wr_done;
   logic          byte0_wr;
   logic [NS-1:0] clr_status;

   // Inputs are already synchronous to pclk
   assign raw_level = {steer_irq_second_input, steer_irq_first_input,
                       pci_int_lines};
   assign rise = raw_level & ~prev_level;

   assign route_code[0] = pci_int_route_1_2[NB-1:0];
   assign route_code[1] = pci_int_route_1_2[2*NB-1:NB];
   assign route_code[2] = pci_int_route_3_4[NB-1:0];
   assign route_code[3] = pci_int_route_3_4[2*NB-1:NB];
   assign route_code[4] = pci_int_route_5_6[NB-1:0];
   assign route_code[5] = pci_int_route_5_6[2*NB-1:NB];
   assign route_code[6] = pci_int_route_7_8[NB-1:0];
   assign route_code[7] = pci_int_route_7_8[2*NB-1:NB];
   assign route_code[8] = steerable_irq_route[NB-1:0];
   assign route_code[9] = steerable_irq_route[2*NB-1:NB];

   // APB: one wait state, write lands on the completing edge
   assign wr_done = psel & penable & pready & pwrite & ~pslverr;
   assign byte0_wr = wr_done & pstrb[0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_level <= irq_steer_pkg::EVT_RESET;
      end else begin
         prev_level <= raw_level;
      end
   end

   // Edge conversion: fixed-width pulse on each fresh assertion
   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_edge
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pulse_cnt[g] <= '0;
            end else if (rise[g] && level_to_edge_enable[g]) begin
               pulse_cnt[g] <= CW'(PULSE_LEN);
            end else if (pulse_cnt[g] != '0) begin
               pulse_cnt[g] <= pulse_cnt[g] - CW'(1);
            end
         end
         assign pulse_on[g] = (pulse_cnt[g] != '0);
         // Level mode passes the request as is
         assign src[g] = level_to_edge_enable[g] ? pulse_on[g]
                                                 : raw_level[g];
      end
   endgenerate
   assign src[NS-1:NP] = raw_level[NS-1:NP];

   generate
      for (g = 0; g < NS; g++) begin : g_dec
         irq_route_decode u_dec (
            .code       (route_code[g]),
            .irq_onehot (route_hot[g])
         );
      end
   endgenerate

   always_comb begin
      next_isa_irq = irq_steer_pkg::IRQ_NONE;
      for (int i = 0; i < NS; i++) begin
         if (src[i]) begin
            next_isa_irq = next_isa_irq | route_hot[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isa_irq <= irq_steer_pkg::IRQ_NONE;
      end else begin
         isa_irq <= next_isa_irq;
      end
   end

   // Routing and conversion registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pci_int_route_1_2    <= irq_steer_pkg::REG_RESET;
         pci_int_route_3_4    <= irq_steer_pkg::REG_RESET;
         pci_int_route_5_6    <= irq_steer_pkg::REG_RESET;
         pci_int_route_7_8    <= irq_steer_pkg::REG_RESET;
         level_to_edge_enable <= irq_steer_pkg::REG_RESET;
         steerable_irq_route  <= irq_steer_pkg::REG_RESET;
      end else if (byte0_wr) begin
         unique case (paddr)
            irq_steer_pkg::ADDR_ROUTE_12: pci_int_route_1_2 <= pwdata[7:0];
            irq_steer_pkg::ADDR_ROUTE_34: pci_int_route_3_4 <= pwdata[7:0];
            irq_steer_pkg::ADDR_ROUTE_56: pci_int_route_5_6 <= pwdata[7:0];
            irq_steer_pkg::ADDR_ROUTE_78: pci_int_route_7_8 <= pwdata[7:0];
            irq_steer_pkg::ADDR_L2E: level_to_edge_enable <= pwdata[7:0];
            irq_steer_pkg::ADDR_STEER: steerable_irq_route <= pwdata[7:0];
            default: begin
            end
         endcase
      end
   end

   // Event status: a rise on any source, write one to clear
   assign clr_status = (wr_done && paddr == irq_steer_pkg::ADDR_INT_STATUS)
                       ? pwdata[NS-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status <= irq_steer_pkg::EVT_RESET;
      end else begin
         // Set beats a clear in the same cycle
         int_status <= (int_status & ~clr_status) | rise;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask <= irq_steer_pkg::EVT_RESET;
      end else if (wr_done && paddr == irq_steer_pkg::ADDR_INT_MASK) begin
         int_mask <= pwdata[NS-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status & int_mask);
      end
   end

   always_comb begin
      next_prdata = irq_steer_pkg::READ_ZERO;
      next_hit = 1'b1;
      unique case (paddr)
         irq_steer_pkg::ADDR_ROUTE_12: next_prdata[7:0] = pci_int_route_1_2;
         irq_steer_pkg::ADDR_ROUTE_34: next_prdata[7:0] = pci_int_route_3_4;
         irq_steer_pkg::ADDR_ROUTE_56: next_prdata[7:0] = pci_int_route_5_6;
         irq_steer_pkg::ADDR_ROUTE_78: next_prdata[7:0] = pci_int_route_7_8;
         irq_steer_pkg::ADDR_L2E: next_prdata[7:0] = level_to_edge_enable;
         irq_steer_pkg::ADDR_STEER: next_prdata[7:0] = steerable_irq_route;
         irq_steer_pkg::ADDR_INT_STATUS: next_prdata[NS-1:0] = int_status;
         irq_steer_pkg::ADDR_INT_MASK: next_prdata[NS-1:0] = int_mask;
         irq_steer_pkg::ADDR_RAW_LEVEL: next_prdata[NS-1:0] = raw_level;
         default: next_hit = 1'b0;
      endcase
   end

   // Raw level is read-only; a write there completes without effect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= irq_steer_pkg::READ_ZERO;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= ~next_hit;
         prdata  <= (next_hit && !pwrite) ? next_prdata
                                          : irq_steer_pkg::READ_ZERO;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_decode_irq9;
      src[0] && route_code[0] == irq_steer_pkg::CODE_IRQ9 |=> isa_irq[9];
   endproperty
   a_decode_irq9: assert property (p_decode_irq9)
      else $error("Code 0001 did not raise IRQ9");

   property p_reserved_off;
      (route_code[0] == irq_steer_pkg::CODE_RSV_A ||
       route_code[0] == irq_steer_pkg::CODE_RSV_C ||
       route_code[0] == irq_steer_pkg::CODE_RSV_E) && src[0] &&
      (src[NS-1:1] == '0) |=> isa_irq == irq_steer_pkg::IRQ_NONE;
   endproperty
   a_reserved_off: assert property (p_reserved_off)
      else $error("Reserved routing code drove an IRQ");

   property p_route_12_write;
      byte0_wr && paddr == irq_steer_pkg::ADDR_ROUTE_12 |=>
         route_code[1] == $past(pwdata[7:4]) &&
         route_code[0] == $past(pwdata[3:0]);
   endproperty
   a_route_12_write: assert property (p_route_12_write)
      else $error("Lines 1 and 2 routing nibbles misplaced");

   property p_route_34_write;
      byte0_wr && paddr == irq_steer_pkg::ADDR_ROUTE_34 |=>
         route_code[3] == $past(pwdata[7:4]) &&
         route_code[2] == $past(pwdata[3:0]);
   endproperty
   a_route_34_write: assert property (p_route_34_write)
      else $error("Lines 3 and 4 routing nibbles misplaced");

   property p_route_56_write;
      byte0_wr && paddr == irq_steer_pkg::ADDR_ROUTE_56 |=>
         route_code[5] == $past(pwdata[7:4]) &&
         route_code[4] == $past(pwdata[3:0]);
   endproperty
   a_route_56_write: assert property (p_route_56_write)
      else $error("Lines 5 and 6 routing nibbles misplaced");

   property p_route_78_write;
      byte0_wr && paddr == irq_steer_pkg::ADDR_ROUTE_78 |=>
         route_code[7] == $past(pwdata[7:4]) &&
         route_code[6] == $past(pwdata[3:0]);
   endproperty
   a_route_78_write: assert property (p_route_78_write)
      else $error("Lines 7 and 8 routing nibbles misplaced");

   property p_steer_write;
      byte0_wr && paddr == irq_steer_pkg::ADDR_STEER |=>
         route_code[9] == $past(pwdata[7:4]) &&
         route_code[8] == $past(pwdata[3:0]);
   endproperty
   a_steer_write: assert property (p_steer_write)
      else $error("Steerable routing nibbles misplaced");

   property p_l2e_write;
      byte0_wr && paddr == irq_steer_pkg::ADDR_L2E |=>
         level_to_edge_enable == $past(pwdata[7:0]);
   endproperty
   a_l2e_write: assert property (p_l2e_write)
      else $error("Conversion register write lost");

   property p_level_pass;
      !level_to_edge_enable[3] && pci_int_lines[3] &&
      route_code[3] == irq_steer_pkg::CODE_IRQ9 |=> isa_irq[9];
   endproperty
   a_level_pass: assert property (p_level_pass)
      else $error("Level request not passed through");

   property p_edge_pulse;
      level_to_edge_enable[0] && rise[0] && $stable(level_to_edge_enable)
         |=> src[0];
   endproperty
   a_edge_pulse: assert property (p_edge_pulse)
      else $error("Edge mode produced no pulse");

   property p_no_retrigger;
      level_to_edge_enable[0] && pulse_cnt[0] == '0 && prev_level[0] &&
      raw_level[0] |=> !src[0] || rise[0];
   endproperty
   a_no_retrigger: assert property (p_no_retrigger)
      else $error("Held level produced a second edge");

   property p_steer_first;
      src[8] && route_code[8] == irq_steer_pkg::CODE_IRQ5 |=> isa_irq[5];
   endproperty
   a_steer_first: assert property (p_steer_first)
      else $error("First steerable input not routed");

   property p_shared_or;
      src[0] && src[1] && route_code[0] == irq_steer_pkg::CODE_IRQ5 &&
      route_code[1] == irq_steer_pkg::CODE_IRQ3 |=> isa_irq[5] && isa_irq[3];
   endproperty
   a_shared_or: assert property (p_shared_or)
      else $error("Simultaneous sources not ORed");

   property p_reset_zero;
      $rose(presetn) |-> level_to_edge_enable == irq_steer_pkg::REG_RESET &&
         steerable_irq_route == irq_steer_pkg::REG_RESET;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("Registers not zero after reset");

   property p_set_wins;
      rise[2] && clr_status[2] |=> int_status[2];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("Event lost under clear");

   property p_apb_ready;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready)
      else $error("APB ready not one cycle after access");

endmodule
`default_nettype wire

// ===== testbench/int_source_model.sv
// Behavioural model of the PCI interrupt sources and steerable inputs
`timescale 1ns/1ps
`default_nettype none
module int_source_model (
   input  wire logic       pclk,
   output logic      [7:0] pci_int_lines,
   output logic            steer_irq_first_input,
   output logic            steer_irq_second_input
);
   initial begin
      pci_int_lines = 8'h00;
      steer_irq_first_input = 1'b0;
      steer_irq_second_input = 1'b0;
   end
   // Levels hold until dropped; lag models a late source
   task automatic drive(input logic [9:0] v, input int lag);
      repeat (lag) @(posedge pclk);
      {steer_irq_second_input, steer_irq_first_input, pci_int_lines} <= v;
   endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the interrupt steering block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic        rd;
      logic [31:0] data;
      logic        err;
   } apb_note_t;
   localparam int PL = 3;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  lines;
   logic        s1;
   logic        s2;
   logic [15:0] isa_irq;
   logic        irq;
   int          n_errors = 0;
   int          n_compared = 0;
   int          cycles = 0;
   integer      seed = 32'hbd92_ef61;
   apb_note_t   apb_q[$];
   logic [16:0] isa_q[$];
   logic [15:0] dec[16] = '{16'h0000, 16'h0200, 16'h0008, 16'h0400,
      16'h0010, 16'h0020, 16'h0080, 16'h0040, 16'h0002, 16'h0800,
      16'h0000, 16'h1000, 16'h0000, 16'h4000, 16'h0000, 16'h8000};

   pci_int_to_isa_irq_steering #(.PULSE_LEN(PL)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pci_int_lines(lines), .steer_irq_first_input(s1),
      .steer_irq_second_input(s2), .isa_irq(isa_irq), .irq(irq));
   int_source_model src (
      .pclk(pclk), .pci_int_lines(lines),
      .steer_irq_first_input(s1), .steer_irq_second_input(s2));

   always #5 pclk = ~pclk;

   task automatic give_verdict();
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cmp_bus(input string what, input logic [31:0] e,
                          input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask

   task automatic cmp_irq(input logic [16:0] e, input logic [16:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected irq,isa_irq: expected %h, seen %h", e, g);
      end
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   // Bus results are taken at the edge that samples pready
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         apb_note_t n;
         n = apb_q.pop_front();
         if (n.rd)
            cmp_bus("prdata", n.data, prdata);
         cmp_bus("pslverr", {31'h0, n.err}, {31'h0, pslverr});
      end
   end

   always @(negedge pclk) begin
      if (isa_q.size() > 0)
         cmp_irq(isa_q.pop_front(), {irq, isa_irq});
   end

   // Idle edge after each transfer so strobes never toggle in one step
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic err);
      apb_q.push_back('{!wr, d, err});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, e, 1'b0);
   endtask

   task automatic exp_isa(input logic [15:0] v, input logic i);
      @(posedge pclk);
      isa_q.push_back({i, v});
   endtask

   function automatic logic [11:0] raddr(input int s);
      if (s > 7)
         return irq_steer_pkg::ADDR_STEER;
      return irq_steer_pkg::ADDR_ROUTE_12 + 12'(4 * (s / 2));
   endfunction

   initial begin
      logic [7:0] v;
      logic [11:0] ra;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int k = 0; k < 6; k++)
         rd(irq_steer_pkg::ADDR_ROUTE_12 + 12'(4 * k), 32'h0000_0000);
      apb(1'b1, 12'h1fc, 32'h0000_00ff, 1'b1);
      apb(1'b0, 12'h1fc, 32'h0000_0000, 1'b1);
      // Every code on every source, reserved ones included
      for (int s = 0; s < 10; s++)
         for (int c = 0; c < 16; c++) begin
            wr(raddr(s), 32'(c) << (4 * (s % 2)));
            src.drive(10'(1) << s, $random(seed) & 3);
            exp_isa(dec[c], 1'b0);
            src.drive(10'h000, 0);
            exp_isa(16'h0000, 1'b0);
         end
      wr(irq_steer_pkg::ADDR_ROUTE_12, 32'h0000_0025);
      wr(irq_steer_pkg::ADDR_STEER, 32'h0000_0005);
      src.drive(10'h003, 1);
      exp_isa(16'h0028, 1'b0);
      src.drive(10'h102, 0);
      exp_isa(16'h0028, 1'b0);
      src.drive(10'h100, 0);
      exp_isa(16'h0020, 1'b0);
      wr(irq_steer_pkg::ADDR_STEER, 32'h0000_0000);
      for (int s = 0; s < 8; s++) begin
         wr(raddr(s), 32'h0000_0011);
         wr(irq_steer_pkg::ADDR_L2E, 32'(1) << s);
         for (int r = 0; r < 2; r++) begin
            src.drive(10'(1) << s, 0);
            exp_isa(16'h0000, 1'b0);
            repeat (PL) exp_isa(irq_steer_pkg::IRQ9_BIT, 1'b0);
            repeat (3) exp_isa(16'h0000, 1'b0);
            src.drive(10'h000, 0);
            exp_isa(16'h0000, 1'b0);
         end
      end
      wr(irq_steer_pkg::ADDR_L2E, 32'h0000_0000);
      wr(irq_steer_pkg::ADDR_INT_STATUS, 32'h0000_03ff);
      rd(irq_steer_pkg::ADDR_INT_STATUS, 32'h0000_0000);
      wr(irq_steer_pkg::ADDR_INT_MASK, 32'h0000_0001);
      src.drive(10'h002, 0);
      repeat (2) exp_isa(irq_steer_pkg::IRQ9_BIT, 1'b0);
      src.drive(10'h003, 0);
      exp_isa(irq_steer_pkg::IRQ9_BIT, 1'b0);
      exp_isa(irq_steer_pkg::IRQ9_BIT, 1'b1);
      rd(irq_steer_pkg::ADDR_INT_STATUS, 32'h0000_0003);
      rd(irq_steer_pkg::ADDR_RAW_LEVEL, 32'h0000_0003);
      wr(irq_steer_pkg::ADDR_INT_STATUS, 32'h0000_0001);
      exp_isa(irq_steer_pkg::IRQ9_BIT, 1'b0);
      wr(irq_steer_pkg::ADDR_INT_MASK, 32'h0000_0003);
      exp_isa(irq_steer_pkg::IRQ9_BIT, 1'b1);
      wr(irq_steer_pkg::ADDR_INT_STATUS, 32'h0000_0002);
      exp_isa(irq_steer_pkg::IRQ9_BIT, 1'b0);
      // Clear and a new rise on line 3 meet at one edge
      fork
         wr(irq_steer_pkg::ADDR_INT_STATUS, 32'h0000_0004);
         src.drive(10'h007, 2);
      join
      rd(irq_steer_pkg::ADDR_INT_STATUS, 32'h0000_0004);
      // Upper bits of the word are not stored
      for (int k = 0; k < 6; k++) begin
         v = 8'($random(seed));
         ra = irq_steer_pkg::ADDR_ROUTE_12 + 12'(4 * k);
         wr(ra, {24'($random(seed)), v});
         rd(ra, {24'h00_0000, v});
      end
      give_verdict();
   end
endmodule
`default_nettype wire
